//--- verilog/cpu_core_regs.svh
// constants of the core register state: register-space address, flag bit
// positions, reset values, stack and program-counter steps.
// assumes the includer compiles it once; definitions only.
`ifndef CPU_CORE_REGS_SVH
`define CPU_CORE_REGS_SVH

// =============================================================
// register space
`define FLAGS_REG_ADDR 8'hf7

// =============================================================
// flag bit positions
`define FLAG_IE_BIT 0
`define FLAG_ZERO_BIT 1
`define FLAG_CARRY_BIT 2
`define FLAG_SUPER_BIT 3
`define FLAG_BANK_BIT 4

// bits that the flag logic instructions may touch: bank, carry, zero, ie
`define FLAGS_USER_MASK 8'h17
// bits that exist at all; 7:5 read as zero
`define FLAGS_READ_MASK 8'h1f

// =============================================================
// reset values
`define FLAGS_RESET 8'h02
`define ACC_RESET 8'h00
`define INDEX_RESET 8'h00
`define SP_RESET 8'h00
`define PC_RESET 16'h0000

// =============================================================
// program counter and stack steps
`define IMM_INSN_BYTES 16'h0002
`define ONE_BYTE_INSN 16'h0001
`define SP_STEP_ONE 8'h01
`define SP_STEP_CALL 8'h02
`define SP_STEP_INTERRUPT_RETURN 8'h03

`endif

//--- verilog/cpu_core_pkg.sv
// types shared by the core register state and its helper modules.
// assumes nothing beyond a SystemVerilog compiler.
package cpu_core_pkg;

	// =============================================================
	// operation codes
	typedef enum logic [3:0] {
		ALU_MOV, ALU_ADD, ALU_ADC, ALU_SUB, ALU_SBB,
		ALU_AND, ALU_OR, ALU_XOR, ALU_CMP, ALU_ASL, ALU_ASR
	} alu_op_t;

	typedef enum logic [1:0] {DST_A, DST_F, DST_SP, DST_X} dst_t;

	typedef enum logic [2:0] {
		STK_PUSH, STK_POP, STK_CALL, STK_LONG_SUBROUTINE_CALL, STK_RET, STK_INTERRUPT_RETURN
	} stack_op_t;

	typedef enum logic [2:0] {
		RQ_IMM, RQ_STACK, RQ_SWAP, RQ_JUMP, RQ_SUPER_ENTER, RQ_SUPER_EXIT
	} req_kind_t;

	// =============================================================
	// carriers
	typedef struct packed {
		logic valid;
		req_kind_t kind;
		alu_op_t op;
		dst_t dst;
		logic [7:0] imm;
		stack_op_t stk;
		logic [15:0] target;
	} req_t;

	typedef struct packed {
		logic [7:0] flags;
		logic [7:0] acc;
		logic [7:0] idx;
		logic [7:0] sp;
		logic [15:0] pc;
		logic [7:0] rd_data;
		logic rd_hit;
	} arch_state_t;

endpackage : cpu_core_pkg

//--- verilog/cpu_alu8.sv
// 8-bit arithmetic and logic unit of the core, purely combinational.
// assumes the caller decides which results to write back.
module cpu_alu8
	import cpu_core_pkg::*;
(
	input wire alu_op_t op_i, // operation
	input wire logic [7:0] a_i, // destination value
	input wire logic [7:0] b_i, // immediate value
	input wire logic carry_i, // current carry flag
	output logic [7:0] res_o, // result
	output logic carry_o, // carry or borrow out
	output logic zero_o, // result equals zero
	output logic flags_o // operation updates flags
);
	logic [8:0] wide;

	always_comb begin
		wide = {1'b0, a_i};
		unique case (op_i)
			ALU_MOV: wide = {1'b0, b_i};
			ALU_ADD: wide = {1'b0, a_i} + {1'b0, b_i};
			ALU_ADC: wide = {1'b0, a_i} + {1'b0, b_i} + {8'h00, carry_i};
			ALU_SUB, ALU_CMP: wide = {1'b0, a_i} - {1'b0, b_i};
			ALU_SBB: wide = {1'b0, a_i} - {1'b0, b_i} - {8'h00, carry_i};
			ALU_AND: wide = {1'b0, a_i & b_i};
			ALU_OR: wide = {1'b0, a_i | b_i};
			ALU_XOR: wide = {1'b0, a_i ^ b_i};
			ALU_ASL: wide = {a_i, 1'b0};
			ALU_ASR: wide = {a_i[0], a_i[7], a_i[7:1]};
			default: wide = {1'b0, a_i};
		endcase
		res_o = wide[7:0];
		carry_o = wide[8];
		zero_o = (wide[7:0] == 8'h00);
		flags_o = (op_i != ALU_MOV);
	end

endmodule : cpu_alu8

//--- verilog/stack_top_pointer_step.sv
// next stack pointer for push, pop, calls and returns.
// assumes one stack operation per request; the pointer wraps in 8 bits.
`include "cpu_core_regs.svh"
module stack_top_pointer_step
	import cpu_core_pkg::*;
(
	input wire stack_op_t stk_i, // stack operation
	input wire logic [7:0] sp_i, // current pointer
	output logic [7:0] sp_o // pointer after the operation
);
	always_comb begin
		unique case (stk_i)
			STK_PUSH: sp_o = sp_i + `SP_STEP_ONE;
			STK_POP: sp_o = sp_i - `SP_STEP_ONE;
			STK_CALL, STK_LONG_SUBROUTINE_CALL: sp_o = sp_i + `SP_STEP_CALL;
			STK_RET: sp_o = sp_i - `SP_STEP_CALL;
			STK_INTERRUPT_RETURN: sp_o = sp_i - `SP_STEP_INTERRUPT_RETURN;
			default: sp_o = sp_i;
		endcase
	end

endmodule : stack_top_pointer_step

//--- verilog/cpu_core_register_state.sv
// architectural register state of the 8-bit core: flags, accumulator,
// index, stack pointer and program counter, plus the one register-space
// window onto the flags.
// assumes the instruction sequencer presents at most one request a cycle
// and that memory traffic for stack and operands is done elsewhere.
`include "cpu_core_regs.svh"

module cpu_core_register_state
	import cpu_core_pkg::*;
#(
	parameter int DATA_W = 8,
	parameter int PROG_BYTES = 8192
) (
	input wire logic sys_clk_i, // core clock, 50 MHz
	input wire logic rst_n_i, // asynchronous reset, active low
	input wire req_t req_i, // instruction request from the sequencer
	input wire logic rd_en_i, // register-space read strobe
	input wire logic [7:0] rd_addr_i, // register-space read address
	output logic [7:0] rd_data_o, // register-space read data
	output logic rd_hit_o, // read address belonged to this block
	output logic [7:0] flags_o, // flags register
	output logic [7:0] acc_o, // accumulator
	output logic [7:0] index_o, // index register
	output logic [7:0] sp_o, // stack pointer
	output logic [7:0] pc_high_o, // program counter bits 15:8
	output logic [7:0] pc_low_o, // program counter bits 7:0
	output logic irq_enable_o, // interrupt master enable
	output logic bank_sel_o, // register bank select
	output logic supervisor_o // supervisor code executing
);

	// =============================================================
	// elaboration checks
	generate
		if (DATA_W != 8) begin : g_bad_width
			$error("core data path must be 8 bits");
		end
		if (PROG_BYTES < 1 || PROG_BYTES > 65536) begin : g_bad_prog
			$error("program memory exceeds counter range");
		end
	endgenerate

	localparam arch_state_t ST_RESET = '{
		flags: `FLAGS_RESET,
		acc: `ACC_RESET,
		idx: `INDEX_RESET,
		sp: `SP_RESET,
		pc: `PC_RESET,
		rd_data: 8'h00,
		rd_hit: 1'b0
	};

	// =============================================================
	// operand selection
	function automatic logic [7:0] dest_value(input arch_state_t s,
		input dst_t d);
		logic [7:0] v;
		v = s.acc;
		unique case (d)
			DST_A: v = s.acc;
			DST_F: v = s.flags;
			DST_SP: v = s.sp;
			DST_X: v = s.idx;
		endcase
		return v;
	endfunction : dest_value

	arch_state_t st_q;
	arch_state_t st_d;
	logic [7:0] alu_a;
	logic [7:0] alu_res;
	logic alu_carry;
	logic alu_zero;
	logic alu_flags;
	logic [7:0] sp_next;
	logic stack_jumps;

	assign alu_a = dest_value(st_q, req_i.dst);

	cpu_alu8 u_alu (
		.op_i(req_i.op),
		.a_i(alu_a),
		.b_i(req_i.imm),
		.carry_i(st_q.flags[`FLAG_CARRY_BIT]),
		.res_o(alu_res),
		.carry_o(alu_carry),
		.zero_o(alu_zero),
		.flags_o(alu_flags)
	);

	stack_top_pointer_step u_sp (
		.stk_i(req_i.stk),
		.sp_i(st_q.sp),
		.sp_o(sp_next)
	);

	assign stack_jumps = (req_i.stk != STK_PUSH) && (req_i.stk != STK_POP);

	// =============================================================
	// next state
	always_comb begin
		st_d = st_q;
		// only the flags answer in register space; all else misses
		st_d.rd_hit = 1'b0;
		st_d.rd_data = 8'h00;
		if (rd_en_i && rd_addr_i == `FLAGS_REG_ADDR) begin
			st_d.rd_hit = 1'b1;
			st_d.rd_data = st_q.flags & `FLAGS_READ_MASK;
		end
		if (req_i.valid) begin
			unique case (req_i.kind)
				RQ_IMM: begin
					st_d.pc = st_q.pc + `IMM_INSN_BYTES;
					unique case (req_i.dst)
						DST_F: begin
							// bit 3 and the reserved bits are outside the mask
							if (req_i.op == ALU_OR) begin
								st_d.flags = st_q.flags |
									(req_i.imm & `FLAGS_USER_MASK);
							end else if (req_i.op == ALU_AND) begin
								st_d.flags = st_q.flags &
									(req_i.imm | ~`FLAGS_USER_MASK);
							end
						end
						DST_A: begin
							if (req_i.op != ALU_CMP) begin
								st_d.acc = alu_res;
							end
						end
						DST_X: begin
							if (req_i.op != ALU_CMP) begin
								st_d.idx = alu_res;
							end
						end
						DST_SP: begin
							// adding to the stack pointer leaves the flags alone
							if (req_i.op != ALU_CMP) begin
								st_d.sp = alu_res;
							end
						end
					endcase
					if (alu_flags && (req_i.dst == DST_A ||
						req_i.dst == DST_X)) begin
						st_d.flags[`FLAG_CARRY_BIT] = alu_carry;
						st_d.flags[`FLAG_ZERO_BIT] = alu_zero;
					end
				end
				RQ_STACK: begin
					st_d.sp = sp_next;
					if (stack_jumps) begin
						st_d.pc = req_i.target;
					end else begin
						st_d.pc = st_q.pc + `ONE_BYTE_INSN;
					end
				end
				RQ_SWAP: begin
					st_d.acc = st_q.sp;
					st_d.sp = st_q.acc;
					st_d.pc = st_q.pc + `ONE_BYTE_INSN;
				end
				RQ_JUMP: begin
					st_d.pc = req_i.target;
				end
				RQ_SUPER_ENTER: begin
					st_d.flags[`FLAG_SUPER_BIT] = 1'b1;
				end
				RQ_SUPER_EXIT: begin
					st_d.flags[`FLAG_SUPER_BIT] = 1'b0;
				end
				default: begin
					st_d = st_d;
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			st_q <= ST_RESET;
		end else begin
			st_q <= st_d;
		end
	end

	// =============================================================
	// outputs, all taken from the state register
	assign rd_data_o = st_q.rd_data;
	assign rd_hit_o = st_q.rd_hit;
	assign flags_o = st_q.flags;
	assign acc_o = st_q.acc;
	assign index_o = st_q.idx;
	assign sp_o = st_q.sp;
	assign pc_high_o = st_q.pc[15:8];
	assign pc_low_o = st_q.pc[7:0];
	assign irq_enable_o = st_q.flags[`FLAG_IE_BIT];
	assign bank_sel_o = st_q.flags[`FLAG_BANK_BIT];
	assign supervisor_o = st_q.flags[`FLAG_SUPER_BIT];

	// =============================================================
	// checks
	logic [8:0] sum_acc;
	logic imm_to_a;
	logic imm_to_f;

	assign sum_acc = {1'b0, st_q.acc} + {1'b0, req_i.imm};
	assign imm_to_a = req_i.valid && req_i.kind == RQ_IMM &&
		req_i.dst == DST_A;
	assign imm_to_f = req_i.valid && req_i.kind == RQ_IMM &&
		req_i.dst == DST_F;

	property p_flag_read;
		@(posedge sys_clk_i) disable iff (!rst_n_i)
		rd_en_i && rd_addr_i == `FLAGS_REG_ADDR |=>
			rd_hit_o && rd_data_o == ($past(flags_o) & `FLAGS_READ_MASK);
	endproperty
	a_flag_read: assert property (p_flag_read)
		else $error("flags read at f7 gave wrong data");

	property p_other_miss;
		@(posedge sys_clk_i) disable iff (!rst_n_i)
		!(rd_en_i && rd_addr_i == `FLAGS_REG_ADDR) |=>
			!rd_hit_o && rd_data_o == 8'h00;
	endproperty
	a_other_miss: assert property (p_other_miss)
		else $error("register space answered outside f7");

	property p_super_kept;
		@(posedge sys_clk_i) disable iff (!rst_n_i)
		imm_to_f |=> $stable(supervisor_o) && flags_o[7:5] == 3'b000;
	endproperty
	a_super_kept: assert property (p_super_kept)
		else $error("flag instruction changed supervisor or reserved bits");

	property p_imm_length;
		@(posedge sys_clk_i) disable iff (!rst_n_i)
		req_i.valid && req_i.kind == RQ_IMM |=>
			{pc_high_o, pc_low_o} == $past(st_q.pc) + `IMM_INSN_BYTES;
	endproperty
	a_imm_length: assert property (p_imm_length)
		else $error("immediate instruction did not advance by two");

	property p_add_acc;
		@(posedge sys_clk_i) disable iff (!rst_n_i)
		imm_to_a && req_i.op == ALU_ADD |=> acc_o == $past(sum_acc[7:0]);
	endproperty
	a_add_acc: assert property (p_add_acc)
		else $error("accumulator add result wrong");

	property p_add_carry;
		@(posedge sys_clk_i) disable iff (!rst_n_i)
		imm_to_a && req_i.op == ALU_ADD |=>
			flags_o[`FLAG_CARRY_BIT] == $past(sum_acc[8]);
	endproperty
	a_add_carry: assert property (p_add_carry)
		else $error("carry flag does not follow add carry");

	property p_add_zero;
		@(posedge sys_clk_i) disable iff (!rst_n_i)
		imm_to_a && req_i.op != ALU_MOV |=>
			flags_o[`FLAG_ZERO_BIT] == (acc_o == 8'h00) ||
			$past(req_i.op) == ALU_CMP;
	endproperty
	a_add_zero: assert property (p_add_zero)
		else $error("zero flag does not follow result");

	property p_or_flags;
		@(posedge sys_clk_i) disable iff (!rst_n_i)
		imm_to_f && req_i.op == ALU_OR |=>
			flags_o == ($past(flags_o) |
			($past(req_i.imm) & `FLAGS_USER_MASK));
	endproperty
	a_or_flags: assert property (p_or_flags)
		else $error("or into flags gave wrong value");

	property p_flags_quiet;
		@(posedge sys_clk_i) disable iff (!rst_n_i)
		!req_i.valid |=> $stable(flags_o) ##1 1'b1;
	endproperty
	a_flags_quiet: assert property (p_flags_quiet)
		else $error("flags changed with no request");

	property p_push_step;
		@(posedge sys_clk_i) disable iff (!rst_n_i)
		req_i.valid && req_i.kind == RQ_STACK && req_i.stk == STK_PUSH |=>
			sp_o == $past(sp_o) + `SP_STEP_ONE;
	endproperty
	a_push_step: assert property (p_push_step)
		else $error("push did not raise stack pointer by one");

	property p_swap_regs;
		@(posedge sys_clk_i) disable iff (!rst_n_i)
		req_i.valid && req_i.kind == RQ_SWAP |=>
			acc_o == $past(sp_o) && sp_o == $past(acc_o);
	endproperty
	a_swap_regs: assert property (p_swap_regs)
		else $error("swap did not exchange accumulator and stack pointer");

	property p_jump_target;
		@(posedge sys_clk_i) disable iff (!rst_n_i)
		req_i.valid && req_i.kind == RQ_JUMP |=>
			{pc_high_o, pc_low_o} == $past(req_i.target);
	endproperty
	a_jump_target: assert property (p_jump_target)
		else $error("jump did not load the program counter");

	property p_cmp_keeps_acc;
		@(posedge sys_clk_i) disable iff (!rst_n_i)
		imm_to_a && req_i.op == ALU_CMP |=> $stable(acc_o);
	endproperty
	a_cmp_keeps_acc: assert property (p_cmp_keeps_acc)
		else $error("compare wrote the accumulator");

	property p_mov_keeps_flags;
		@(posedge sys_clk_i) disable iff (!rst_n_i)
		imm_to_a && req_i.op == ALU_MOV |=> $stable(flags_o);
	endproperty
	a_mov_keeps_flags: assert property (p_mov_keeps_flags)
		else $error("move into accumulator changed the flags");

	property p_super_enter;
		@(posedge sys_clk_i) disable iff (!rst_n_i)
		req_i.valid && req_i.kind == RQ_SUPER_ENTER |=> supervisor_o;
	endproperty
	a_super_enter: assert property (p_super_enter)
		else $error("supervisor entry did not set the state bit");

endmodule : cpu_core_register_state

//--- test/cpu_core_register_state_tb_top.sv
// self-checking bench of the core register state, with an integer model.
// assumes the design and its package are compiled first.
`include "cpu_core_regs.svh"
module cpu_core_register_state_tb_top
	import cpu_core_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic sys_clk_i = 1'b0;
	logic rst_n_i = 1'b0;
	req_t req_i = '0;
	logic rd_en_i = 1'b0;
	logic [7:0] rd_addr_i = 8'h00;
	logic [7:0] rd_data_o, flags_o, acc_o, index_o, sp_o, pc_high_o;
	logic [7:0] pc_low_o;
	logic rd_hit_o, irq_enable_o, bank_sel_o, supervisor_o;
	int failures = 0;
	int compares = 0;
	int unsigned seed = 25844;
	int m_f, m_a, m_x, m_sp, m_pc, m_rd, m_hit;
	req_t idle_r = '0;
	// register-space addresses around the flags, the last one a hit
	logic [7:0] probe_q[$] = '{8'hf6, 8'hf8, 8'h00, 8'hff, 8'hf7};

	always #10 sys_clk_i = ~sys_clk_i;

	cpu_core_register_state i_dut (
		.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .req_i(req_i),
		.rd_en_i(rd_en_i), .rd_addr_i(rd_addr_i), .rd_data_o(rd_data_o),
		.rd_hit_o(rd_hit_o), .flags_o(flags_o), .acc_o(acc_o),
		.index_o(index_o), .sp_o(sp_o), .pc_high_o(pc_high_o),
		.pc_low_o(pc_low_o), .irq_enable_o(irq_enable_o),
		.bank_sel_o(bank_sel_o), .supervisor_o(supervisor_o)
	);

	// =============================================================
	// helpers
	function automatic int unsigned xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : xs

	function automatic req_t mk(req_kind_t k, alu_op_t o, dst_t d,
		logic [7:0] i, stack_op_t s = STK_PUSH, logic [15:0] t = 16'h0000);
		req_t r;
		r = '{1'b1, k, o, d, i, s, t};
		return r;
	endfunction : mk

	function automatic req_t rnd_req();
		req_t r;
		r.valid = 1'b1;
		r.kind = req_kind_t'(xs() % 6);
		r.op = alu_op_t'(xs() % 11);
		r.dst = dst_t'(xs() % 4);
		// a stack pointer destination is only moved or added to
		if (r.dst == DST_SP && r.op != ALU_MOV) r.op = ALU_ADD;
		r.imm = 8'(xs());
		r.stk = stack_op_t'(xs() % 6);
		r.target = 16'(xs());
		return r;
	endfunction : rnd_req

	task automatic model_reset();
		m_f = `FLAGS_RESET;
		m_a = 0;
		m_x = 0;
		m_sp = 0;
		m_pc = 0;
		m_rd = 0;
		m_hit = 0;
	endtask : model_reset

	task automatic model_imm(req_t r);
		int a, b, c, res, cy, upd;
		a = r.dst == DST_A ? m_a : r.dst == DST_X ? m_x :
			r.dst == DST_SP ? m_sp : m_f;
		b = r.imm;
		c = m_f[2];
		cy = 0;
		upd = 1;
		case (r.op)
			ALU_MOV: begin
				res = b;
				upd = 0;
			end
			ALU_ADD: begin
				res = a + b;
				cy = res >> 8;
			end
			ALU_ADC: begin
				res = a + b + c;
				cy = res >> 8;
			end
			ALU_SUB, ALU_CMP: begin
				res = a - b;
				cy = a < b;
			end
			ALU_SBB: begin
				res = a - b - c;
				cy = a < b + c;
			end
			ALU_AND: res = a & b;
			ALU_OR: res = a | b;
			ALU_XOR: res = a ^ b;
			ALU_ASL: begin
				res = a << 1;
				cy = a >> 7;
			end
			default: begin
				res = (a >> 1) | (a & 8'h80);
				cy = a & 1;
			end
		endcase
		res = res & 8'hff;
		if (r.dst == DST_F) begin
			if (r.op == ALU_OR) m_f = m_f | (b & `FLAGS_USER_MASK);
			if (r.op == ALU_AND) m_f = m_f & (b | 8'he8);
		end else begin
			if (r.op != ALU_CMP && r.dst == DST_A) m_a = res;
			if (r.op != ALU_CMP && r.dst == DST_X) m_x = res;
			if (r.op != ALU_CMP && r.dst == DST_SP) m_sp = res;
			if (r.dst != DST_SP && upd)
				m_f = (m_f & 8'hf9) | (res == 0 ? 2 : 0) | (cy ? 4 : 0);
		end
		m_pc = m_pc + 2;
	endtask : model_imm

	task automatic model_req(req_t r);
		int t;
		case (r.kind)
			RQ_IMM: model_imm(r);
			RQ_STACK: begin
				case (r.stk)
					STK_PUSH: begin
						m_sp++;
						m_pc++;
					end
					STK_POP: begin
						m_sp--;
						m_pc++;
					end
					STK_CALL, STK_LONG_SUBROUTINE_CALL: begin
						m_sp += 2;
						m_pc = r.target;
					end
					STK_RET: begin
						m_sp -= 2;
						m_pc = r.target;
					end
					default: begin
						m_sp -= 3;
						m_pc = r.target;
					end
				endcase
			end
			RQ_SWAP: begin
				t = m_a;
				m_a = m_sp;
				m_sp = t;
				m_pc++;
			end
			RQ_JUMP: m_pc = r.target;
			RQ_SUPER_ENTER: m_f = m_f | 8'h08;
			default: m_f = m_f & 8'hf7;
		endcase
		m_sp = m_sp & 8'hff;
		m_pc = m_pc & 16'hffff;
	endtask : model_req

	// =============================================================
	// comparisons
	task automatic check8(string n, logic [7:0] got, logic [7:0] exp);
		compares++;
		if (got !== exp) begin
			failures++;
			$display("Error at %0t: %s got %h expected %h", $time, n, got, exp);
		end
	endtask : check8

	task automatic check1(string n, logic got, logic exp);
		compares++;
		if (got !== exp) begin
			failures++;
			$display("Error at %0t: %s got %h expected %h", $time, n, got, exp);
		end
	endtask : check1

	task automatic check_all();
		check8("flags", flags_o, 8'(m_f));
		check8("acc", acc_o, 8'(m_a));
		check8("index", index_o, 8'(m_x));
		check8("sp", sp_o, 8'(m_sp));
		check8("pc_high", pc_high_o, 8'(m_pc >> 8));
		check8("pc_low", pc_low_o, 8'(m_pc));
		check8("rd_data", rd_data_o, 8'(m_rd));
		check1("rd_hit", rd_hit_o, m_hit[0]);
		check1("irq_en", irq_enable_o, m_f[0]);
		check1("bank", bank_sel_o, m_f[4]);
		check1("super", supervisor_o, m_f[3]);
	endtask : check_all

	// drive at the falling edge, check one cycle later
	task automatic step(req_t r, logic re = 1'b1, logic [7:0] ad = 8'hf7);
		req_i = r;
		rd_en_i = re;
		rd_addr_i = ad;
		m_hit = re && ad == `FLAGS_REG_ADDR;
		m_rd = m_hit ? m_f : 0;
		if (r.valid) model_req(r);
		@(negedge sys_clk_i);
		check_all();
	endtask : step

	task automatic give_verdict();
		$display("compares %0d failures %0d", compares, failures);
		if (failures == 0 && compares > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : give_verdict

	// =============================================================
	// tests
	initial begin
		#100000;
		failures++;
		give_verdict();
	end

	initial begin
		model_reset();
		repeat (4) @(negedge sys_clk_i);
		check_all();
		rst_n_i = 1'b1;
		$display("test reset done");
		// carry and zero at the wrap, borrow below zero
		step(mk(RQ_IMM, ALU_MOV, DST_A, 8'hff));
		step(mk(RQ_IMM, ALU_ADD, DST_A, 8'h01));
		step(mk(RQ_IMM, ALU_SUB, DST_A, 8'h01));
		for (int o = 0; o < 11; o++) begin
			step(mk(RQ_IMM, alu_op_t'(o), DST_A, 8'(xs())));
			step(mk(RQ_IMM, alu_op_t'(o), DST_X, 8'(xs())));
		end
		$display("test alu done");
		step(mk(RQ_IMM, ALU_OR, DST_F, 8'hff));
		for (int o = 0; o < 11; o++) begin
			step(mk(RQ_IMM, alu_op_t'(o), DST_F, 8'h00));
		end
		step(mk(RQ_SUPER_ENTER, ALU_MOV, DST_A, 8'h00));
		step(mk(RQ_IMM, ALU_AND, DST_F, 8'h00));
		step(mk(RQ_IMM, ALU_OR, DST_F, 8'h11));
		step(mk(RQ_SUPER_EXIT, ALU_MOV, DST_A, 8'h00));
		$display("test flags done");
		step(mk(RQ_IMM, ALU_MOV, DST_SP, 8'hfe));
		step(mk(RQ_IMM, ALU_ADD, DST_SP, 8'h03));
		for (int s = 0; s < 6; s++) begin
			step(mk(RQ_STACK, ALU_MOV, DST_A, 8'h00, stack_op_t'(s),
				16'(xs())));
		end
		step(mk(RQ_SWAP, ALU_MOV, DST_A, 8'h00));
		step(mk(RQ_JUMP, ALU_MOV, DST_A, 8'h00, STK_PUSH,
			16'h1fff));
		$display("test stack done");
		// neighbours of the flags address are not in this block
		foreach (probe_q[i]) begin
			step(mk(RQ_IMM, ALU_OR, DST_F, 8'h04), 1'b1,
				probe_q[i]);
		end
		step(idle_r, 1'b0);
		$display("test reads done");
		repeat (300)
			step(rnd_req(), xs() % 2 == 0, xs() % 3 == 0 ? 8'hf7 :
				8'(xs()));
		$display("test random done");
		step(mk(RQ_IMM, ALU_OR, DST_F, 8'h17));
		rst_n_i = 1'b0;
		model_reset();
		#5;
		check_all();
		@(negedge sys_clk_i);
		rst_n_i = 1'b1;
		step(mk(RQ_IMM, ALU_ADD, DST_X, 8'h80));
		step(mk(RQ_IMM, ALU_CMP, DST_X, 8'h80));
		$display("test second reset done");
		give_verdict();
	end
endmodule : cpu_core_register_state_tb_top
